// [hdl/eem_pkg.sv]
/*
  eeprom emulation manager: shared constants, field positions, timing counts
  and carrier types. assumes a 10 MHz flash clock and a plain register port.
*/
// Operation
// - backup records are 32 bits: tag, halfword index and data
// - only written halfwords ever get a record
// - byte, halfword and word accesses accepted
// - program about 100 us, erase+program 1.5 ms
// - disabled: ram is plain 4 KB memory
// - disabled: no flash program or erase issued
// - emulation ram runs on flash clock
// - enabled: data only through ram window
// - writes tracked, flash operations generated automatically
// - emulated size 32 bytes to 4 KB, powers of two
// - two subsystems, equal backup flash share each
// - first subsystem gets eighth, quarter or half
// - unallocated secondary flash stays ordinary data flash
// - program flash never touched by this block
package eem_pkg;
    // memory geometry
    localparam int RAM_BYTES = 4096;
    localparam int RAM_WORDS = RAM_BYTES / 4;
    localparam int BUS_ADDR_W = 13;
    localparam int MIN_EMU_BYTES = 32;
    localparam int FLASH_ADDR_W = 18;
    localparam int FLASH_BLOCK_UNITS = 8; // secondary flash block in 32 KB units
    localparam int HALF_UNIT_SHIFT = 14; // half of a 32 KB backup unit
    // register offsets
    localparam logic [12:0] CTRL_OFS = 13'h1000;
    localparam logic [12:0] STATUS_OFS = 13'h1004;
    localparam logic [12:0] COUNT_OFS = 13'h1008;
    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SIZE_LSB = 1;
    localparam int CTRL_SPLIT_LSB = 4;
    localparam int CTRL_PART_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DROP_BIT = 1;
    localparam int STAT_CFGERR_BIT = 2;
    // tag value marking a live record
    localparam logic [4:0] REC_VALID = 5'h15;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_US = 100;
    localparam int ERASE_PROG_TIME_US = 1500;
    localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int ERASE_PROG_CYCLES = (ERASE_PROG_TIME_US * 1000) / CLK_PERIOD_NS;

    // share of the emulated size given to the first subsystem
    typedef enum logic [1:0] {
        SPLIT_EIGHTH = 2'h0,
        SPLIT_QUARTER = 2'h1,
        SPLIT_HALF = 2'h2
    } eem_split_t;
    // access width on the bus
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } eem_size_t;
    // backup state machine, gray along the usual path
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FETCH = 2'h1,
        ST_ISSUE = 2'h3,
        ST_WAIT = 2'h2
    } eem_state_t;
    // one backup record
    typedef struct packed {
        logic [4:0] tag;
        logic [10:0] halfIdx;
        logic [15:0] data;
    } eem_record_t;
    // command toward the secondary flash block
    typedef struct packed {
        logic prog;
        logic erase;
        logic [FLASH_ADDR_W-1:0] addr;
        eem_record_t record;
    } eem_flash_cmd_t;
    // register port request
    typedef struct packed {
        logic [BUS_ADDR_W-1:0] addr;
        eem_size_t size;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } eem_bus_req_t;
endpackage

// [hdl/eem_ram.sv]
/*
  emulation ram: word memory with byte lanes, one read/write port and one
  read port, both with registered read data. assumes one clock, the flash clock.
*/
module eem_ram #(
    parameter int WORDS = 1024,
    parameter int AW = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bus port
    input wire logic [AW-1:0] aAddr,
    input wire logic aWe,
    input wire logic [3:0] aBe,
    input wire logic [31:0] aWdata,
    output logic [31:0] aRdata,
    // backup port
    input wire logic [AW-1:0] bAddr,
    output logic [31:0] bRdata
);
    logic [31:0] mem [WORDS]; // storage array

    // byte lane writes; one process so the array keeps a single writer
    always_ff @(posedge clk) begin
        for (int g = 0; g < 4; g++) begin
            if (aWe && aBe[g]) begin
                mem[aAddr][8*g+:8] <= aWdata[8*g+:8];
            end
        end
    end

    // registered reads, old data on a same-cycle write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aRdata <= 32'h0000_0000;
            bRdata <= 32'h0000_0000;
        end else begin
            aRdata <= mem[aAddr];
            bRdata <= mem[bAddr];
        end
    end
endmodule

// [hdl/eem_manager.sv]
/*
  eeprom emulation manager: ram window, control registers and the backup
  state machine that streams records toward the secondary flash block.
  assumes the flash macro accepts a command pulse and is timed by this block.
*/
module eem_manager #(
    parameter int PROG_CYCLES = eem_pkg::PROG_CYCLES,
    parameter int ERASE_PROG_CYCLES = eem_pkg::ERASE_PROG_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register and ram port
    input wire eem_pkg::eem_bus_req_t busReq,
    output logic [31:0] busRdata,
    // flash side
    output eem_pkg::eem_flash_cmd_t flashCmd,
    output logic [eem_pkg::FLASH_ADDR_W-1:0] dataFlashBase,
    // status
    output logic busy
);
    // control register fields
    logic emuEnable;
    logic [2:0] sizeCode;
    eem_pkg::eem_split_t split;
    logic [3:0] partUnits;
    logic dropped; // sticky: a write was refused
    // derived configuration
    logic cfgOk;
    logic emuOn;
    logic [12:0] totalBytes;
    logic [12:0] sizeABytes;
    logic [eem_pkg::FLASH_ADDR_W-1:0] halfBytes;
    logic [15:0] slotsPerHalf;
    // bus decode
    logic isRam;
    logic winOk;
    logic ramWe;
    logic refused;
    logic [3:0] mask;
    logic [31:0] ramRdata;
    logic rdRam;
    logic [31:0] rdRegVal;
    // backup engine
    eem_pkg::eem_state_t state;
    logic pendLo;
    logic pendHi;
    logic [9:0] pendWord;
    logic [31:0] backRdata;
    logic [15:0] ptrA;
    logic [15:0] ptrB;
    logic [15:0] waitCnt;
    // issue-time values
    logic [10:0] halfIdx;
    logic subB;
    logic [15:0] ptrSel;
    logic wrap;

    // byte lanes touched by an access
    function automatic logic [3:0] laneMask(eem_pkg::eem_size_t sz, logic [1:0] lo);
        case (sz)
            eem_pkg::SZ_BYTE: laneMask = 4'h1 << lo;
            eem_pkg::SZ_HALF: laneMask = lo[1] ? 4'hC : 4'h3;
            default: laneMask = 4'hF;
        endcase
    endfunction

    // configuration decode
    always_comb begin
        cfgOk = (partUnits != 4'h0) && (partUnits <= 4'(eem_pkg::FLASH_BLOCK_UNITS));
        emuOn = emuEnable && cfgOk;
        totalBytes = 13'(eem_pkg::MIN_EMU_BYTES) << sizeCode;
        case (split)
            eem_pkg::SPLIT_HALF: sizeABytes = totalBytes >> 1;
            eem_pkg::SPLIT_QUARTER: sizeABytes = totalBytes >> 2;
            default: sizeABytes = totalBytes >> 3;
        endcase
        halfBytes = eem_pkg::FLASH_ADDR_W'(partUnits) << eem_pkg::HALF_UNIT_SHIFT;
        slotsPerHalf = 16'(halfBytes >> 2);
    end

    // backup region sits at the bottom; the rest stays data flash
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dataFlashBase <= '0;
        end else if (emuOn) begin
            dataFlashBase <= halfBytes << 1;
        end else begin
            dataFlashBase <= '0;
        end
    end

    // access decode; the ram is addressed only through this window
    always_comb begin
        mask = laneMask(busReq.size, busReq.addr[1:0]);
        isRam = !busReq.addr[12];
        winOk = !emuOn || (busReq.addr < totalBytes);
        refused = busReq.wr && isRam && winOk && emuOn && busy;
        ramWe = busReq.wr && isRam && winOk && !refused;
    end

    eem_ram #(
        .WORDS(eem_pkg::RAM_WORDS),
        .AW(10)
    ) uRam (
        .clk(clk),
        .rstn(rstn),
        .aAddr(busReq.addr[11:2]),
        .aWe(ramWe),
        .aBe(mask),
        .aWdata(busReq.wdata),
        .aRdata(ramRdata),
        .bAddr(pendWord),
        .bRdata(backRdata)
    );

    // control register writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            emuEnable <= eem_pkg::CTRL_RESET[eem_pkg::CTRL_EN_BIT];
            sizeCode <= eem_pkg::CTRL_RESET[eem_pkg::CTRL_SIZE_LSB+:3];
            split <= eem_pkg::eem_split_t'(eem_pkg::CTRL_RESET[eem_pkg::CTRL_SPLIT_LSB+:2]);
            partUnits <= eem_pkg::CTRL_RESET[eem_pkg::CTRL_PART_LSB+:4];
        end else if (busReq.wr && busReq.addr == eem_pkg::CTRL_OFS) begin
            emuEnable <= busReq.wdata[eem_pkg::CTRL_EN_BIT];
            sizeCode <= busReq.wdata[eem_pkg::CTRL_SIZE_LSB+:3];
            // the unused split code falls back to one half
            if (busReq.wdata[eem_pkg::CTRL_SPLIT_LSB+:2] == 2'h3) begin
                split <= eem_pkg::SPLIT_HALF;
            end else begin
                split <= eem_pkg::eem_split_t'(busReq.wdata[eem_pkg::CTRL_SPLIT_LSB+:2]);
            end
            partUnits <= busReq.wdata[eem_pkg::CTRL_PART_LSB+:4];
        end
    end

    // refused-write flag: set wins over the write-one clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dropped <= 1'b0;
        end else if (refused) begin
            dropped <= 1'b1;
        end else if (busReq.wr && busReq.addr == eem_pkg::STATUS_OFS && busReq.wdata[eem_pkg::STAT_DROP_BIT]) begin
            dropped <= 1'b0;
        end
    end

    // read path: capture register value, ram data come from its own register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdRam <= 1'b0;
            rdRegVal <= 32'h0000_0000;
        end else begin
            rdRam <= busReq.rd && isRam && winOk;
            rdRegVal <= 32'h0000_0000;
            if (busReq.rd) begin
                case (busReq.addr)
                    eem_pkg::CTRL_OFS: begin
                        rdRegVal[eem_pkg::CTRL_EN_BIT] <= emuEnable;
                        rdRegVal[eem_pkg::CTRL_SIZE_LSB+:3] <= sizeCode;
                        rdRegVal[eem_pkg::CTRL_SPLIT_LSB+:2] <= split;
                        rdRegVal[eem_pkg::CTRL_PART_LSB+:4] <= partUnits;
                    end
                    eem_pkg::STATUS_OFS: begin
                        rdRegVal[eem_pkg::STAT_BUSY_BIT] <= busy;
                        rdRegVal[eem_pkg::STAT_DROP_BIT] <= dropped;
                        rdRegVal[eem_pkg::STAT_CFGERR_BIT] <= emuEnable && !cfgOk;
                    end
                    eem_pkg::COUNT_OFS: begin
                        rdRegVal <= {ptrB, ptrA};
                    end
                    default: begin
                        rdRegVal <= 32'h0000_0000; // unmapped or outside window
                    end
                endcase
            end
        end
    end

    // read data stand in the cycle after the strobe only
    assign busRdata = rdRam ? ramRdata : rdRegVal;

    // busy while anything is queued or in flight
    assign busy = (state != eem_pkg::ST_IDLE) || pendLo || pendHi;

    // issue-time selection of the halfword and its subsystem
    always_comb begin
        halfIdx = {pendWord, !pendLo};
        subB = {1'b0, halfIdx, 1'b0} >= sizeABytes;
        ptrSel = subB ? ptrB : ptrA;
        wrap = ptrSel >= slotsPerHalf;
    end

    // pending halfwords: only written locations are queued
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pendLo <= 1'b0;
            pendHi <= 1'b0;
            pendWord <= 10'h000;
        end else if (ramWe && emuOn) begin
            pendLo <= |mask[1:0];
            pendHi <= |mask[3:2];
            pendWord <= busReq.addr[11:2];
        end else if (!emuOn) begin
            pendLo <= 1'b0;
            pendHi <= 1'b0;
        end else if (state == eem_pkg::ST_ISSUE) begin
            if (pendLo) begin
                pendLo <= 1'b0;
            end else begin
                pendHi <= 1'b0;
            end
        end
    end

    // backup state machine and operation timer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= eem_pkg::ST_IDLE;
            waitCnt <= 16'h0000;
        end else if (!emuOn) begin
            state <= eem_pkg::ST_IDLE;
            waitCnt <= 16'h0000;
        end else begin
            case (state)
                eem_pkg::ST_IDLE: begin
                    if (pendLo || pendHi) begin
                        state <= eem_pkg::ST_FETCH;
                    end
                end
                eem_pkg::ST_FETCH: begin
                    state <= eem_pkg::ST_ISSUE; // merged word now readable
                end
                eem_pkg::ST_ISSUE: begin
                    state <= eem_pkg::ST_WAIT;
                    waitCnt <= wrap ? 16'(ERASE_PROG_CYCLES - 1) : 16'(PROG_CYCLES - 1);
                end
                eem_pkg::ST_WAIT: begin
                    if (waitCnt != 16'h0000) begin
                        waitCnt <= waitCnt - 16'h0001;
                    end else if (pendLo || pendHi) begin
                        state <= eem_pkg::ST_ISSUE; // second half of the word
                    end else begin
                        state <= eem_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= eem_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // record pointers per subsystem, restarted after an erase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptrA <= 16'h0000;
            ptrB <= 16'h0000;
        end else if (!emuOn) begin
            ptrA <= 16'h0000;
            ptrB <= 16'h0000;
        end else if (state == eem_pkg::ST_ISSUE) begin
            if (subB) begin
                ptrB <= wrap ? 16'h0001 : ptrB + 16'h0001;
            end else begin
                ptrA <= wrap ? 16'h0001 : ptrA + 16'h0001;
            end
        end
    end

    // flash command pulse: one record, erase first when the half is full
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flashCmd <= '0;
        end else begin
            flashCmd.prog <= 1'b0;
            flashCmd.erase <= 1'b0;
            if (state == eem_pkg::ST_ISSUE && emuOn) begin
                flashCmd.prog <= 1'b1;
                flashCmd.erase <= wrap;
                flashCmd.addr <= (subB ? halfBytes : '0) +
                    (wrap ? '0 : eem_pkg::FLASH_ADDR_W'({ptrSel, 2'b00}));
                flashCmd.record.tag <= eem_pkg::REC_VALID;
                flashCmd.record.halfIdx <= halfIdx;
                flashCmd.record.data <= pendLo ? backRdata[15:0] : backRdata[31:16];
            end
        end
    end

    // assertion helpers: wait length and kind of the running operation
    logic [15:0] opLen;
    logic opErase;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opLen <= 16'h0000;
            opErase <= 1'b0;
        end else if (state == eem_pkg::ST_ISSUE) begin
            opLen <= 16'h0001;
            opErase <= wrap;
        end else if (state == eem_pkg::ST_WAIT) begin
            opLen <= opLen + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_no_flash_when_off;
        !$past(emuOn) |-> !flashCmd.prog && !flashCmd.erase;
    endproperty
    a_no_flash_when_off: assert property (p_no_flash_when_off) else $error("flash op while emulation off");

    property p_op_length;
        (state == eem_pkg::ST_WAIT && waitCnt == 16'h0000 && emuOn) |->
            opLen == 16'(opErase ? ERASE_PROG_CYCLES : PROG_CYCLES);
    endproperty
    a_op_length: assert property (p_op_length) else $error("backup op length wrong");

    property p_record_tag;
        flashCmd.prog |-> flashCmd.record.tag == eem_pkg::REC_VALID && $past(state) == eem_pkg::ST_ISSUE;
    endproperty
    a_record_tag: assert property (p_record_tag) else $error("bad record tag");

    property p_record_data;
        flashCmd.prog |-> flashCmd.record.data ==
            ($past(pendLo) ? $past(backRdata[15:0]) : $past(backRdata[31:16]));
    endproperty
    a_record_data: assert property (p_record_data) else $error("record data mismatch");

    property p_only_written;
        (state == eem_pkg::ST_IDLE && !pendLo && !pendHi) |=> !flashCmd.prog;
    endproperty
    a_only_written: assert property (p_only_written) else $error("record without write");

    property p_refuse_busy;
        refused |=> dropped && $past(!ramWe);
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("write accepted while busy");

    property p_split_share;
        sizeABytes == (totalBytes >> (split == eem_pkg::SPLIT_HALF ? 1 : split == eem_pkg::SPLIT_QUARTER ? 2 : 3));
    endproperty
    a_split_share: assert property (p_split_share) else $error("split share wrong");

    property p_sub_b_region;
        (flashCmd.prog && $past(subB)) |-> flashCmd.addr >= $past(halfBytes);
    endproperty
    a_sub_b_region: assert property (p_sub_b_region) else $error("subsystem b outside its half");

    property p_window;
        (busReq.rd && isRam && emuOn && busReq.addr >= totalBytes) |=> busRdata == 32'h0000_0000;
    endproperty
    a_window: assert property (p_window) else $error("read beyond emulated window");

    property p_size_range;
        totalBytes >= 13'(eem_pkg::MIN_EMU_BYTES) && $onehot(totalBytes);
    endproperty
    a_size_range: assert property (p_size_range) else $error("emulated size not power of two");

    c_plain_prog: cover property (flashCmd.prog && !flashCmd.erase);
    c_erase_prog: cover property (flashCmd.prog && flashCmd.erase);
    c_two_records: cover property (state == eem_pkg::ST_WAIT && waitCnt == 16'h0000 && pendHi);
    c_refused: cover property (refused);
endmodule

// [sim/eem_bus_master.sv]
/*
  bus master model: drives the register and ram port of the manager.
  assumes callers enter its tasks just after a rising clock edge.
*/
module eem_bus_master (
    // clock
    input wire logic clk,
    // request toward the manager
    output eem_pkg::eem_bus_req_t busReq
);
    timeunit 1ns;
    timeprecision 1ns;

    // nothing requested at time zero
    initial begin
        busReq = '0;
    end

    // one strobe cycle; strobe stays up so another access may follow at once
    task automatic acc(input logic w, input logic [12:0] a, input eem_pkg::eem_size_t s, input logic [31:0] d);
        busReq <= '{addr: a, size: s, wdata: d, wr: w, rd: !w};
        @(posedge clk);
    endtask

    // released bus: strobes low, address and data toggle so nothing stale lingers
    task automatic idle(input int n);
        repeat (n) begin
            busReq <= '{addr: ~busReq.addr, size: busReq.size, wdata: ~busReq.wdata, wr: 1'b0, rd: 1'b0};
            @(posedge clk);
        end
    endtask
endmodule

// [sim/eeprom_emulation_manager_test.sv]
/*
  self-checking bench for the emulation manager: reads and backup records are
  noted in queues and checked by a watcher. assumes a 10 MHz clock.
*/
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin nFail++; $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end

module eeprom_emulation_manager_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PROG_C = 8; // shortened program time
    localparam int ERASE_C = 40; // shortened erase+program time
    logic clk = 1'b0;
    logic rstn = 1'b0; // active low
    eem_pkg::eem_bus_req_t busReq;
    logic [31:0] busRdata;
    eem_pkg::eem_flash_cmd_t flashCmd;
    logic [eem_pkg::FLASH_ADDR_W-1:0] dataFlashBase;
    logic busy;
    int nFail = 0;
    int checked = 0;
    logic [31:0] seed = 32'hB86AE192;
    logic [31:0] mem [1024]; // ram model
    logic [31:0] rdQ [$]; // expected read data
    eem_pkg::eem_flash_cmd_t cmdQ [$]; // expected flash commands
    logic en = 1'b0; // emulation active in the model
    int winBytes = 4096, aBytes = 4, halfB = 0, ptrA = 0, ptrB = 0;
    int cyc = 0, lastCyc = -100000;
    logic lastEr = 1'b0, rdLast = 1'b0;

    eem_bus_master master_u (.clk(clk), .busReq(busReq));
    eem_manager #(.PROG_CYCLES(PROG_C), .ERASE_PROG_CYCLES(ERASE_C)) dut_u (.clk(clk), .rstn(rstn),
        .busReq(busReq), .busRdata(busRdata), .flashCmd(flashCmd), .dataFlashBase(dataFlashBase), .busy(busy));

    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end

    // xorshift source of data
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // verdict and end of run
    task automatic wrap_up();
        if (nFail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // note one record for a halfword, following its subsystem's slot pointer
    task automatic exp_rec(input int hIdx);
        eem_pkg::eem_flash_cmd_t c;
        logic subB;
        int p;
        subB = (hIdx * 2 >= aBytes);
        p = subB ? ptrB : ptrA;
        c.erase = (p == halfB / 4);
        if (c.erase)
            p = 0;
        c.prog = 1'b1;
        c.addr = 18'(p * 4 + (subB ? halfB : 0));
        c.record = '{tag: eem_pkg::REC_VALID, halfIdx: 11'(hIdx), data: mem[hIdx / 2][(hIdx % 2) * 16 +: 16]};
        cmdQ.push_back(c);
        if (subB)
            ptrB = p + 1;
        else
            ptrA = p + 1;
    endtask

    // write through the port; model ram and backup unless dropped
    task automatic wr(input logic [12:0] a, input eem_pkg::eem_size_t s, input logic [31:0] d, input logic drop);
        logic [3:0] be;
        be = (s == eem_pkg::SZ_BYTE) ? 4'h1 << a[1:0] : (s == eem_pkg::SZ_HALF) ? 4'h3 << {a[1], 1'b0} : 4'hF;
        master_u.acc(1'b1, a, s, d);
        if (a < 13'h1000 && !drop && (!en || a < winBytes)) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i])
                    mem[a[11:2]][i * 8 +: 8] = d[i * 8 +: 8];
            end
            for (int h = 0; h < 2; h++) begin
                if (en && be[2 * h +: 2] != 2'h0)
                    exp_rec(int'(a[11:2]) * 2 + h);
            end
        end
    endtask

    // read with a noted expectation
    task automatic rd(input logic [12:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        master_u.acc(1'b0, a, eem_pkg::eem_size_t'(2'(xs() % 3)), xs());
    endtask

    // expected ram word, zero outside the window
    function automatic logic [31:0] ram(input logic [12:0] a);
        return (en && a >= winBytes) ? 32'h0 : mem[a[11:2]];
    endfunction

    // bounded wait for the backup machine to go quiet
    task automatic wait_idle();
        int n;
        n = 0;
        master_u.idle(2);
        while (busy !== 1'b0 && n < 200) begin
            master_u.idle(1);
            n++;
        end
        if (n == 200) begin
            nFail++;
            wrap_up();
        end
    endtask

    // set the control word and mirror it in the model
    task automatic cfg(input logic [31:0] v);
        wr(eem_pkg::CTRL_OFS, eem_pkg::SZ_WORD, v, 1'b0);
        en = v[0] && v[11:8] != 4'h0 && v[11:8] <= 4'h8;
        winBytes = 32 << v[3:1];
        aBytes = winBytes >> (3 - v[5:4]);
        halfB = v[11:8] * 16384;
        if (!en) begin
            ptrA = 0;
            ptrB = 0;
        end
        master_u.idle(2);
        `CHK(dataFlashBase, 18'(en ? 2 * halfB : 0))
        rd(eem_pkg::CTRL_OFS, v);
    endtask

    // watcher: read data one cycle after the strobe, commands on each pulse
    always @(posedge clk) begin
        eem_pkg::eem_flash_cmd_t e;
        logic [31:0] r;
        cyc++;
        if (rdLast) begin
            `CHK(rdQ.size() != 0, 1'b1)
            r = rdQ.size() != 0 ? rdQ.pop_front() : 32'h0;
            `CHK(busRdata, r)
        end
        rdLast = busReq.rd;
        if (flashCmd.prog || flashCmd.erase) begin
            `CHK(cmdQ.size() != 0, 1'b1)
            `CHK(cyc - lastCyc >= (lastEr ? ERASE_C : PROG_C), 1'b1)
            e = cmdQ.size() != 0 ? cmdQ.pop_front() : '0;
            `CHK(flashCmd, e)
            lastCyc = cyc;
            lastEr = flashCmd.erase;
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        nFail++;
        wrap_up();
    end

    // main sequence
    initial begin
        logic [31:0] t [3];
        t = '{32'h0000_0101, 32'h0000_0213, 32'h0000_042F};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK(busy, 1'b0)
        rd(eem_pkg::CTRL_OFS, 32'h0);
        rd(eem_pkg::STATUS_OFS, 32'h0);
        rd(eem_pkg::COUNT_OFS, 32'h0);
        rd(13'h100C, 32'h0);
        // plain ram: clear all of it, then lane writes at the top
        for (int i = 0; i < 1024; i++) begin
            wr(13'(i * 4), eem_pkg::SZ_WORD, 32'h0, 1'b0);
        end
        wr(13'hFFC, eem_pkg::SZ_WORD, xs(), 1'b0);
        wr(13'hFFD, eem_pkg::SZ_BYTE, xs(), 1'b0);
        rd(13'hFFC, ram(13'hFFC));
        // enable with no partition: configuration error and no backup
        cfg(32'h1);
        rd(eem_pkg::STATUS_OFS, 32'h4);
        wr(13'h0, eem_pkg::SZ_WORD, xs(), 1'b0);
        // size, split and partition settings
        foreach (t[k]) begin
            cfg(32'h0);
            cfg(t[k]);
            wr(13'(aBytes - 2), eem_pkg::SZ_HALF, xs(), 1'b0);
            wait_idle();
            wr(13'(aBytes), eem_pkg::SZ_HALF, xs(), 1'b0);
            wait_idle();
            wr(13'(aBytes + 3), eem_pkg::SZ_BYTE, xs(), 1'b0);
            wait_idle();
            if (winBytes < 4096) begin
                wr(13'(winBytes), eem_pkg::SZ_WORD, xs(), 1'b0);
                rd(13'(winBytes), 32'h0);
            end
            rd(13'(aBytes - 2), ram(13'(aBytes - 2)));
            rd(13'(aBytes), ram(13'(aBytes)));
            rd(eem_pkg::COUNT_OFS, {16'(ptrB), 16'(ptrA)});
            master_u.idle(1);
        end
        // back-to-back write while busy is refused and flagged
        cfg(32'h0);
        cfg(32'h0000_0113);
        wr(13'h0, eem_pkg::SZ_WORD, xs(), 1'b0);
        wr(13'h4, eem_pkg::SZ_WORD, xs(), 1'b1);
        master_u.idle(1);
        `CHK(busy, 1'b1)
        rd(eem_pkg::STATUS_OFS, 32'h3);
        wr(eem_pkg::STATUS_OFS, eem_pkg::SZ_WORD, 32'h2, 1'b0);
        rd(13'h4, ram(13'h4));
        wait_idle();
        rd(eem_pkg::STATUS_OFS, 32'h0);
        // fill subsystem A until its half wraps through an erase
        for (int n = 0; n < 2048; n++) begin
            wr(13'((n % 4) * 4), eem_pkg::SZ_WORD, xs(), 1'b0);
            wait_idle();
        end
        // reset in mid-run: control word back to zero, ram contents kept
        rstn <= 1'b0;
        master_u.idle(2);
        rstn <= 1'b1;
        en = 1'b0;
        ptrA = 0;
        ptrB = 0;
        master_u.idle(1);
        `CHK(busy, 1'b0)
        rd(eem_pkg::CTRL_OFS, 32'h0);
        rd(13'h8, ram(13'h8));
        // disabled again: plain ram, no backup traffic
        cfg(32'h0);
        wr(13'h10, eem_pkg::SZ_WORD, xs(), 1'b0);
        master_u.idle(PROG_C * 4);
        rd(13'h10, ram(13'h10));
        master_u.idle(2);
        `CHK(cmdQ.size(), 0)
        `CHK(rdQ.size(), 0)
        wrap_up();
    end
endmodule
